/* common/pcs_pkg.sv */
package pcs_pkg;

    // Configuration offsets, byte addresses as printed
    localparam logic [7:0]  STATUS_OFS   = 8'h06;
    localparam logic [7:0]  CLASS_OFS    = 8'h08;
    localparam logic [7:0]  TENURE_OFS   = 8'h0c;

    // Reset values
    localparam logic [15:0] STATUS_RST   = 16'h0210;
    localparam logic [7:0]  TENURE_RST   = 8'h00;
    localparam logic [7:0]  LINE_RST     = 8'h00;

    // Status field positions
    localparam int          PAR_BIT      = 15;
    localparam int          SYS_BIT      = 14;
    localparam int          MAB_BIT      = 13;
    localparam int          TAR_BIT      = 12;
    localparam int          TAS_BIT      = 11;
    localparam int          DPAR_BIT     = 8;

    // Hardwired status fields
    localparam logic [1:0]  DEVSEL_MEDIUM           = 2'h1;
    localparam logic        BACK_TO_BACK_CAPABLE    = 1'h0;
    localparam logic        USER_FEATURE_SUPPORT    = 1'h0;
    localparam logic        DOUBLE_SPEED_CAPABLE    = 1'h0;
    localparam logic        CAPABILITY_LIST_PRESENT = 1'h1;

    // Class code fields
    localparam logic [7:0]  BASE_CATEGORY     = 8'h0c;
    localparam logic [7:0]  SUB_CATEGORY      = 8'h00;
    localparam logic [7:0]  PROGRAMMING_MODEL = 8'h10;

    typedef enum logic {PCS_IDLE, PCS_COUNT} pcs_ten_state_t;

endpackage

/* common/pcs_ten_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pcs_ten_if;
    logic [7:0] limit;
    logic       start;
    logic       active;
    logic       gnt_high;
    logic       stop;
    logic       expired;

    modport regs  (output limit, output start, output active, output gnt_high,
                   input stop, input expired);
    modport timer (input limit, input start, input active, input gnt_high,
                   output stop, output expired);
endinterface
`default_nettype wire

/* src/pcs_tenure.sv */
`timescale 1ns/100ps
`default_nettype none
module pcs_tenure (
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  resetn,
    // Register side
    pcs_ten_if.timer   ten
);
    import pcs_pkg::*;

    pcs_ten_state_t state_r;
    pcs_ten_state_t state_nxt;
    logic [7:0]     cnt_r;
    logic [7:0]     cnt_nxt;
    logic           expired_r;
    logic           expired_nxt;
    logic           stop_r;
    logic           stop_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            PCS_IDLE:
            begin
                if (ten.start)
                begin
                    state_nxt = PCS_COUNT;
                    cnt_nxt   = 8'h00;
                end
            end
            PCS_COUNT:
            begin
                if (!ten.active)
                    state_nxt = PCS_IDLE;
                else if (ten.start)
                    cnt_nxt = 8'h00;
                else if (cnt_r != 8'hff)
                    cnt_nxt = cnt_r + 8'h01;
            end
        endcase
        // Saturate so a long burst cannot wrap back under the limit
        expired_nxt = (state_nxt == PCS_COUNT) && (cnt_nxt >= ten.limit);
        stop_nxt    = expired_nxt && ten.gnt_high && ten.active;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r   <= PCS_IDLE;
            cnt_r     <= 8'h00;
            expired_r <= 1'b0;
            stop_r    <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            expired_r <= expired_nxt;
            stop_r    <= stop_nxt;
        end
    end

    assign ten.stop    = stop_r;
    assign ten.expired = expired_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_count_restart: assert property (
        ten.start |=> (cnt_r == 8'h00))
        else $error("tenure count did not restart from zero");

    a_stop_cause: assert property (
        stop_r |-> $past(ten.gnt_high && ten.active && cnt_nxt >= ten.limit))
        else $error("stop without expiry and released grant");

endmodule
`default_nettype wire

/* src/pcs_cfg_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module pcs_cfg_regs #(
    // Arbitrary neutral revision code
    parameter logic [7:0] SILICON_REV = 8'h0a
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Configuration access
    input  wire logic        cfg_req,
    input  wire logic        cfg_we,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output var  logic        cfg_ack_r,
    output var  logic [31:0] cfg_rdata_r,
    // Command register enables
    input  wire logic        parity_response_enable,
    input  wire logic        system_error_enable,
    // Bus events
    input  wire logic        parity_fault_evt,
    input  wire logic        system_error_evt,
    input  wire logic        master_abort_evt,
    input  wire logic        target_abort_in_evt,
    input  wire logic        target_abort_out_evt,
    input  wire logic        perr_observed,
    input  wire logic        master_data_phase,
    // Bus tenure
    input  wire logic        frame_start,
    input  wire logic        xfer_active,
    input  wire logic        gnt_n_pin,
    output logic             tenure_stop,
    output logic             tenure_expired,
    output var  logic [7:0]  tenure_limit_r,
    output var  logic [7:0]  line_size_words_r
);
    import pcs_pkg::*;

    // Write-one-to-clear with the hardware set taking priority
    function automatic logic flag_next(input logic cur, input logic clr, input logic set);
        flag_next = (cur && !clr) || set;
    endfunction

    // Byte-lane merge for writable fields
    function automatic logic [7:0] lane_merge(input logic [7:0] cur, input logic en, input logic [7:0] wd);
        lane_merge = en ? wd : cur;
    endfunction

    logic [5:0]  cfg_dw;
    logic        wr_stat;
    logic        wr_ten;
    logic [15:0] stat_clr;
    logic [15:0] status_rd;

    // Status flag group
    logic parity_error_seen_r;
    logic parity_error_seen_nxt;
    logic system_error_signaled_r;
    logic system_error_signaled_nxt;
    logic master_abort_received_r;
    logic master_abort_received_nxt;
    logic target_abort_received_r;
    logic target_abort_received_nxt;
    logic target_abort_signaled_r;
    logic target_abort_signaled_nxt;
    logic master_data_parity_flag_r;
    logic master_data_parity_flag_nxt;

    // Tenure and line size group
    logic [7:0] tenure_limit_nxt;
    logic [7:0] line_size_words_nxt;

    // Answer group
    logic        cfg_ack_nxt;
    logic [31:0] cfg_rdata_nxt;
    logic [5:0]  rsp_dw_r;
    logic [5:0]  rsp_dw_nxt;

    // Grant pin synchroniser
    logic gnt_meta_r;
    logic gnt_sync_r;

    pcs_ten_if ten ();

    assign cfg_dw  = cfg_addr[7:2];
    assign wr_stat = cfg_req && cfg_we && (cfg_dw == STATUS_OFS[7:2]);
    assign wr_ten  = cfg_req && cfg_we && (cfg_dw == TENURE_OFS[7:2]);

    // Status sits in the upper half of its dword, lanes 2 and 3
    assign stat_clr = wr_stat ? {(cfg_be[3] ? cfg_wdata[31:24] : 8'h00),
                                 (cfg_be[2] ? cfg_wdata[23:16] : 8'h00)} : 16'h0000;

    assign status_rd = {parity_error_seen_r,
                        system_error_signaled_r,
                        master_abort_received_r,
                        target_abort_received_r,
                        target_abort_signaled_r,
                        DEVSEL_MEDIUM,
                        master_data_parity_flag_r,
                        BACK_TO_BACK_CAPABLE,
                        USER_FEATURE_SUPPORT,
                        DOUBLE_SPEED_CAPABLE,
                        CAPABILITY_LIST_PRESENT,
                        STATUS_RST[3:0]};

    always_comb
    begin
        parity_error_seen_nxt = flag_next(parity_error_seen_r,
            stat_clr[PAR_BIT], parity_fault_evt);
        system_error_signaled_nxt = flag_next(system_error_signaled_r,
            stat_clr[SYS_BIT], system_error_evt && system_error_enable);
        master_abort_received_nxt = flag_next(master_abort_received_r,
            stat_clr[MAB_BIT], master_abort_evt);
        target_abort_received_nxt = flag_next(target_abort_received_r,
            stat_clr[TAR_BIT], target_abort_in_evt);
        target_abort_signaled_nxt = flag_next(target_abort_signaled_r,
            stat_clr[TAS_BIT], target_abort_out_evt);
        master_data_parity_flag_nxt = flag_next(master_data_parity_flag_r,
            stat_clr[DPAR_BIT],
            perr_observed && master_data_phase && parity_response_enable);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            parity_error_seen_r       <= STATUS_RST[PAR_BIT];
            system_error_signaled_r   <= STATUS_RST[SYS_BIT];
            master_abort_received_r   <= STATUS_RST[MAB_BIT];
            target_abort_received_r   <= STATUS_RST[TAR_BIT];
            target_abort_signaled_r   <= STATUS_RST[TAS_BIT];
            master_data_parity_flag_r <= STATUS_RST[DPAR_BIT];
        end
        else
        begin
            parity_error_seen_r       <= parity_error_seen_nxt;
            system_error_signaled_r   <= system_error_signaled_nxt;
            master_abort_received_r   <= master_abort_received_nxt;
            target_abort_received_r   <= target_abort_received_nxt;
            target_abort_signaled_r   <= target_abort_signaled_nxt;
            master_data_parity_flag_r <= master_data_parity_flag_nxt;
        end
    end

    always_comb
    begin
        tenure_limit_nxt    = lane_merge(tenure_limit_r, wr_ten && cfg_be[1], cfg_wdata[15:8]);
        line_size_words_nxt = lane_merge(line_size_words_r, wr_ten && cfg_be[0], cfg_wdata[7:0]);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tenure_limit_r    <= TENURE_RST;
            line_size_words_r <= LINE_RST;
        end
        else
        begin
            tenure_limit_r    <= tenure_limit_nxt;
            line_size_words_r <= line_size_words_nxt;
        end
    end

    // Class dword is constant, so its writes simply fall through
    always_comb
    begin
        cfg_ack_nxt   = cfg_req;
        rsp_dw_nxt    = cfg_req ? cfg_dw : rsp_dw_r;
        cfg_rdata_nxt = cfg_rdata_r;
        if (cfg_req && !cfg_we)
        begin
            if (cfg_dw == STATUS_OFS[7:2])
                cfg_rdata_nxt = {status_rd, 16'h0000};
            else if (cfg_dw == CLASS_OFS[7:2])
                cfg_rdata_nxt = {BASE_CATEGORY, SUB_CATEGORY,
                                 PROGRAMMING_MODEL, SILICON_REV};
            else if (cfg_dw == TENURE_OFS[7:2])
                cfg_rdata_nxt = {16'h0000, tenure_limit_r, line_size_words_r};
            else
                cfg_rdata_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_ack_r   <= 1'b0;
            cfg_rdata_r <= 32'h0000_0000;
            rsp_dw_r    <= 6'h00;
        end
        else
        begin
            cfg_ack_r   <= cfg_ack_nxt;
            cfg_rdata_r <= cfg_rdata_nxt;
            rsp_dw_r    <= rsp_dw_nxt;
        end
    end

    // Grant comes from the arbiter pin, outside our timing
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            gnt_meta_r <= 1'b1;
            gnt_sync_r <= 1'b1;
        end
        else
        begin
            gnt_meta_r <= gnt_n_pin;
            gnt_sync_r <= gnt_meta_r;
        end
    end

    assign ten.limit    = tenure_limit_r;
    assign ten.start    = frame_start;
    assign ten.active   = xfer_active;
    assign ten.gnt_high = gnt_sync_r;

    pcs_tenure u_tenure (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ten     (ten)
    );

    // Both come straight from flip-flops inside the tenure timer
    assign tenure_stop    = ten.stop;
    assign tenure_expired = ten.expired;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_parity_set: assert property (
        parity_fault_evt |=> parity_error_seen_r)
        else $error("parity flag not set");

    a_serr_gate: assert property (
        $rose(system_error_signaled_r) |-> $past(system_error_evt && system_error_enable))
        else $error("system error flag set without enabled event");

    a_master_abort_set: assert property (
        master_abort_evt |=> master_abort_received_r)
        else $error("master abort flag not set");

    a_target_abort_in: assert property (
        target_abort_in_evt |=> target_abort_received_r)
        else $error("received target abort flag not set");

    a_target_abort_out: assert property (
        target_abort_out_evt |=> target_abort_signaled_r)
        else $error("signaled target abort flag not set");

    a_data_parity_cause: assert property (
        $rose(master_data_parity_flag_r)
            |-> $past(perr_observed && master_data_phase && parity_response_enable))
        else $error("data parity flag set without all three conditions");

    a_status_fixed: assert property (
        (cfg_ack_r && rsp_dw_r == STATUS_OFS[7:2] && $past(!cfg_we))
            |-> (cfg_rdata_r[26:25] == 2'h1 && cfg_rdata_r[23:20] == 4'h1))
        else $error("hardwired status bits wrong");

    a_w1c_clear: assert property (
        (wr_stat && cfg_be[3] && cfg_wdata[31] && !parity_fault_evt) |=> !parity_error_seen_r)
        else $error("write one did not clear parity flag");

    a_class_read: assert property (
        (cfg_req && !cfg_we && cfg_dw == CLASS_OFS[7:2])
            |=> (cfg_ack_r && cfg_rdata_r == {24'h0c0010, SILICON_REV}))
        else $error("class register read wrong");

    a_tenure_write: assert property (
        (wr_ten && cfg_be[1] && cfg_be[0])
            |=> (tenure_limit_r == $past(cfg_wdata[15:8]) && line_size_words_r == $past(cfg_wdata[7:0])))
        else $error("tenure or line size write lost");

endmodule
`default_nettype wire

/* dv/pcs_bus_agent.sv */
`timescale 1ns/100ps
`default_nettype none
module pcs_bus_agent (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Bench control
    input  wire logic go,
    input  wire logic gnt_deny,
    // Initiator and arbiter lines
    input  wire logic tenure_stop,
    output var  logic frame_start,
    output var  logic xfer_active,
    output wire logic gnt_n_pin
);
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            frame_start <= 1'b0;
            xfer_active <= 1'b0;
        end
        else
        begin
            frame_start <= go && !xfer_active;
            if (go && !xfer_active)
                xfer_active <= 1'b1;
            else if (tenure_stop)
                xfer_active <= 1'b0;
        end
    end

    // Arbiter grant, low while granted
    assign gnt_n_pin = gnt_deny;
endmodule
`default_nettype wire

/* dv/pcs_cfg_regs_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module pcs_cfg_regs_tb_top;
    import pcs_pkg::*;
    // Arbitrary revision code for this run
    localparam logic [7:0] REV = 8'h5a;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        cfg_req = 1'b0;
    logic        cfg_we = 1'b0;
    logic [7:0]  cfg_addr = 8'h00;
    logic [3:0]  cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic        cfg_ack_r;
    logic [31:0] cfg_rdata_r;
    logic        pr_en = 1'b0;
    logic        se_en = 1'b0;
    logic [4:0]  evts = 5'h0;
    logic        perr_obs = 1'b0;
    logic        mdp = 1'b0;
    logic        go = 1'b0;
    logic        gnt_deny = 1'b0;
    logic        frame_start;
    logic        xfer_active;
    logic        gnt_n_pin;
    logic        tenure_stop;
    logic        tenure_expired;
    logic [7:0]  lim_r;
    logic [7:0]  line_r;
    logic [31:0] rd;
    logic [31:0] w;
    logic [3:0]  b;
    logic [7:0]  lim;
    logic [7:0]  exp_lim = 8'h00;
    logic [7:0]  exp_line = 8'h00;
    int          n;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          seed = 5992;

    always #2 clk_sys = ~clk_sys;

    pcs_cfg_regs #(.SILICON_REV(REV)) DUT (
        .clk_sys(clk_sys), .resetn(resetn), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack_r(cfg_ack_r),
        .cfg_rdata_r(cfg_rdata_r), .parity_response_enable(pr_en), .system_error_enable(se_en),
        .parity_fault_evt(evts[0]), .system_error_evt(evts[1]), .master_abort_evt(evts[2]),
        .target_abort_in_evt(evts[3]), .target_abort_out_evt(evts[4]), .perr_observed(perr_obs),
        .master_data_phase(mdp), .frame_start(frame_start), .xfer_active(xfer_active),
        .gnt_n_pin(gnt_n_pin), .tenure_stop(tenure_stop), .tenure_expired(tenure_expired),
        .tenure_limit_r(lim_r), .line_size_words_r(line_r));

    pcs_bus_agent agent (
        .clk_sys(clk_sys), .resetn(resetn), .go(go), .gnt_deny(gnt_deny), .tenure_stop(tenure_stop),
        .frame_start(frame_start), .xfer_active(xfer_active), .gnt_n_pin(gnt_n_pin));

    function automatic logic [31:0] stat(input logic [15:0] flags);
        return {STATUS_RST | flags, 16'h0};
    endfunction

    function automatic logic [15:0] fbit(input int i);
        // The five event flags sit one below the other from the parity flag down, bits 15 to 11
        return 16'h1 << (PAR_BIT - i);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Events ride along in the request cycle to test set-versus-clear
    task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                       input logic [4:0] ev);
        @(posedge clk_sys);
        cfg_req <= 1'b1;
        cfg_we <= we;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= wd;
        evts <= ev;
        @(posedge clk_sys);
        cfg_req <= 1'b0;
        evts <= 5'h0;
        #1;
        chk("ack", 32'h1, {31'h0, cfg_ack_r});
        rd = cfg_rdata_r;
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        acc(1'b0, STATUS_OFS, 4'hf, 32'h0, 5'h0);
        chk("status reset", stat(16'h0), rd);
        acc(1'b1, CLASS_OFS, 4'hf, 32'hffffffff, 5'h0);
        acc(1'b0, CLASS_OFS, 4'hf, 32'h0, 5'h0);
        chk("class", {8'h0c, 8'h00, 8'h10, REV}, rd);
        acc(1'b0, TENURE_OFS, 4'hf, 32'h0, 5'h0);
        chk("tenure reset", 32'h0, rd);
        acc(1'b0, 8'h10, 4'hf, 32'h0, 5'h0);
        chk("unmapped", 32'h0, rd);
        @(posedge clk_sys);
        se_en <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            acc(1'b0, STATUS_OFS, 4'h0, 32'h0, 5'h1 << i);
            acc(1'b0, STATUS_OFS, 4'hf, 32'h0, 5'h0);
            chk("flag set", stat(fbit(i)), rd);
            acc(1'b1, STATUS_OFS, 4'hc, 32'h0, 5'h0);
            acc(1'b0, STATUS_OFS, 4'hf, 32'h0, 5'h0);
            chk("zero write keeps", stat(fbit(i)), rd);
            acc(1'b1, STATUS_OFS, 4'h8, {fbit(i), 16'h0}, 5'h0);
            acc(1'b0, STATUS_OFS, 4'hf, 32'h0, 5'h0);
            chk("one write clears", stat(16'h0), rd);
        end
        @(posedge clk_sys);
        se_en <= 1'b0;
        acc(1'b0, STATUS_OFS, 4'h0, 32'h0, 5'h2);
        acc(1'b0, STATUS_OFS, 4'hf, 32'h0, 5'h0);
        chk("system error gated", stat(16'h0), rd);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk_sys);
            perr_obs <= k[0];
            mdp <= k[1];
            pr_en <= k[2];
            @(posedge clk_sys);
            perr_obs <= 1'b0;
            mdp <= 1'b0;
            acc(1'b0, STATUS_OFS, 4'hf, 32'h0, 5'h0);
            chk("data parity", stat(k == 7 ? 16'h0100 : 16'h0), rd);
            acc(1'b1, STATUS_OFS, 4'h8, 32'hff000000, 5'h0);
        end
        acc(1'b1, STATUS_OFS, 4'h8, 32'hff000000, 5'h1);
        acc(1'b0, STATUS_OFS, 4'hf, 32'h0, 5'h0);
        chk("set beats clear", stat(16'h8000), rd);
        acc(1'b1, STATUS_OFS, 4'h8, 32'hff000000, 5'h0);
        repeat (20)
        begin
            w = $random(seed);
            b = 4'($random(seed));
            acc(1'b1, STATUS_OFS, b, w & 32'h00ffffff, 5'h0);
            acc(1'b1, TENURE_OFS, b, w, 5'h0);
            if (b[0])
                exp_line = w[7:0];
            if (b[1])
                exp_lim = w[15:8];
            acc(1'b0, STATUS_OFS, 4'hf, 32'h0, 5'h0);
            chk("status fixed", stat(16'h0), rd);
            acc(1'b0, TENURE_OFS, 4'hf, 32'h0, 5'h0);
            chk("tenure dword", {16'h0, exp_lim, exp_line}, rd);
            chk("line out", {24'h0, exp_line}, {24'h0, line_r});
            chk("limit out", {24'h0, exp_lim}, {24'h0, lim_r});
        end
        for (int j = 0; j < 4; j++)
        begin
            lim = (j == 0) ? 8'h00 : 8'($random(seed) & 31);
            acc(1'b1, TENURE_OFS, 4'h2, {16'h0, lim, 8'h0}, 5'h0);
            @(posedge clk_sys);
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            @(posedge clk_sys);
            #1;
            n = 0;
            while (tenure_expired !== 1'b1 && n < 300)
            begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            chk("tenure count", {24'h0, lim}, 32'(n));
            repeat (4) @(posedge clk_sys);
            #1;
            chk("stop while granted", 32'h0, {31'h0, tenure_stop});
            @(posedge clk_sys);
            gnt_deny <= 1'b1;
            n = 0;
            while (tenure_stop !== 1'b1 && n < 8)
            begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            chk("grant to stop", 32'h1, {31'h0, tenure_stop === 1'b1 && n <= 3});
            repeat (3) @(posedge clk_sys);
            #1;
            chk("transfer ended", 32'h0, {30'h0, xfer_active, tenure_stop});
            @(posedge clk_sys);
            gnt_deny <= 1'b0;
        end
        close_out();
    end

    // Whole run needs well under 5000 cycles
    initial
    begin
        #200000;
        error_cnt++;
        $display("MISMATCH watchdog expected finish seen hang");
        close_out();
    end
endmodule
`default_nettype wire
